/* cbs_params.svh */
// Purpose: constants for the control bus, sync and ready pin block
// Assumes: internal clock i_core_clk at 40 MHz
// Notes:   offsets are register addresses on the five-bit control address bus
`ifndef CBS_PARAMS_SVH
`define CBS_PARAMS_SVH

`define CBS_ADDR_SYNC_MODE    5'h00
`define CBS_ADDR_DEC_MODE     5'h01
`define CBS_ADDR_OUT_CTRL     5'h08
`define CBS_ADDR_STATUS       5'h0e

`define CBS_SYNC_MODE_RST     8'h65
`define CBS_DEC_MODE_RST      8'h00
`define CBS_OUT_CTRL_RST      8'h00

// sync mode register fields
`define CBS_SM_OUT_LSB        4
`define CBS_SM_USE_OS_BIT     6
`define CBS_SM_ONE_SHOT_BIT   7
// decimation mode register fields
`define CBS_DM_READY_POLARITY_BIT_BIT    2
`define CBS_DM_RDY_WIDTH_BIT  3
`define CBS_DM_LINK_BIT       4
// output control register field
`define CBS_OC_DRIVE_BIT      0

`define CBS_RDY_SHORT_CYC     5'h04
`define CBS_RDY_LONG_CYC      5'h10
`define CBS_SO_DELAY_CYC      3

`endif

/* cbs_pkg.sv */
// Purpose: shared types for the control bus block
// Assumes: nothing
// Notes:   sync sources follow the two-bit sync mode encoding
package cbs_pkg;
  typedef enum logic [1:0] {
    CBS_SYNC_NEVER,
    CBS_SYNC_INPUT,
    CBS_SYNC_COUNT,
    CBS_SYNC_ALWAYS
  } cbs_sync_src_e;
endpackage

/* cbs_sync3.sv */
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input is asynchronous to i_core_clk
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module cbs_sync3 #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      s1_r   <= RST;
      s2_r   <= RST;
      s3_r   <= RST;
      o_sync <= RST;
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          o_sync[i] <= s2_r[i];
        end
      end
    end
  end
endmodule // cbs_sync3
`default_nettype wire

/* cbs_timebase_if.sv */
// Purpose: carries the sampling timebase tick between modules
// Assumes: one clock domain
// Notes:   tick marks a rising sampling timebase edge
`timescale 1ns/1ps
`default_nettype none
interface cbs_timebase_if;
  logic tick;
  logic phase;
  modport src (output tick, output phase);
  modport dst (input tick, input phase);
endinterface
`default_nettype wire

/* cbs_timebase.sv */
// Purpose: clock source selection and sampling timebase edge detection
// Assumes: timebase pins arrive already synchronised
// Notes:   in normal mode the internal rate is twice the timebase, so
//          every timebase half period gives one phase pulse
`timescale 1ns/1ps
`default_nettype none
module cbs_timebase (
  input  wire logic   i_core_clk,
  input  wire logic   i_reset,
  input  wire logic   i_timing_source_select,
  input  wire logic   i_sampling_timebase,
  input  wire logic   i_double_rate_timebase,
  cbs_timebase_if.src tb
);
  logic tb_prev_r;
  logic dr_prev_r;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      tb_prev_r <= 1'b0;
      dr_prev_r <= 1'b0;
    end else begin
      tb_prev_r <= i_sampling_timebase;
      dr_prev_r <= i_double_rate_timebase;
    end
  end

  assign tb.tick  = i_sampling_timebase & ~tb_prev_r;
  // alternate mode steps on double rate; normal mode doubles timebase
  assign tb.phase = i_timing_source_select ?
                    (i_double_rate_timebase & ~dr_prev_r) :
                    (i_sampling_timebase ^ tb_prev_r);
endmodule // cbs_timebase
`default_nettype wire

/* cbs_ctrl_port.sv */
// Purpose: control register port, ready/ack pin and sync pins
// Assumes: host strobes are asynchronous and held several core clocks
// Notes:   registers sit on the five-bit control address bus
`timescale 1ns/1ps
`default_nettype none
`include "cbs_params.svh"
module cbs_ctrl_port import cbs_pkg::*; (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_chip_sel_n,
  input  wire logic       i_read_n,
  input  wire logic       i_write_n,
  input  wire logic [4:0] i_addr,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  input  wire logic       i_sampling_timebase,
  input  wire logic       i_double_rate_timebase,
  input  wire logic       i_timing_source_select,
  input  wire logic       i_output_sample_period,
  input  wire logic       i_counter_terminal_pulse,
  input  wire logic [3:0] i_chan_data,
  input  wire logic       i_sync_n,
  input  wire logic       i_ready_ack,
  output logic            o_ready_ack,
  output logic            o_ready_ack_oe,
  output logic            o_link_ack_handshake,
  output logic            o_sync_n,
  output logic            o_sync_event,
  output logic [3:0]      o_chan_sample
);
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [16:0] pins_s;
  logic        cs_n_s;
  logic        rd_n_s;
  logic        wr_n_s;
  logic [4:0]  addr_s;
  logic [7:0]  din_s;
  logic [3:0]  tb_s;
  logic [3:0]  chan_s;
  logic        si_n_s;
  logic        ack_s;

  cbs_sync3 #(.W(17), .RST(17'h1c000)) u_sync_bus (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_async    ({i_chip_sel_n, i_read_n, i_write_n, i_addr, i_data, i_ready_ack}),
    .o_sync     (pins_s)
  );
  cbs_sync3 #(.W(4), .RST(4'h0)) u_sync_chan (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_async    (i_chan_data),
    .o_sync     (chan_s)
  );
  cbs_sync3 #(.W(4), .RST(4'h8)) u_sync_tb (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_async    ({i_sync_n, i_sampling_timebase, i_double_rate_timebase,
                  i_timing_source_select}),
    .o_sync     (tb_s)
  );
  assign {cs_n_s, rd_n_s, wr_n_s, addr_s, din_s, ack_s} = pins_s;
  assign si_n_s = tb_s[3];

  cbs_timebase_if tbi ();
  cbs_timebase u_tb (
    .i_core_clk             (i_core_clk),
    .i_reset                (i_reset),
    .i_timing_source_select (tb_s[0]),
    .i_sampling_timebase    (tb_s[2]),
    .i_double_rate_timebase (tb_s[1]),
    .tb                     (tbi)
  );

  // ****************************************
  // control registers
  // ****************************************
  logic [7:0] sync_mode_r;
  logic [7:0] dec_mode_r;
  logic [7:0] out_ctrl_r;
  logic       wr_n_d_r;
  logic       wr_go;
  logic       one_shot_pend_r;
  logic       one_shot_r;

  // strobes count only with select low
  assign wr_go = ~cs_n_s & ~wr_n_s & wr_n_d_r;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      wr_n_d_r <= 1'b1;
    end else begin
      wr_n_d_r <= wr_n_s | cs_n_s;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sync_mode_r <= `CBS_SYNC_MODE_RST;
      dec_mode_r  <= `CBS_DEC_MODE_RST;
      out_ctrl_r  <= `CBS_OUT_CTRL_RST;
    end else begin
      if (wr_go && addr_s == `CBS_ADDR_SYNC_MODE) begin
        sync_mode_r <= din_s;
      end else if (wr_go && addr_s == `CBS_ADDR_DEC_MODE) begin
        dec_mode_r <= din_s;
      end else if (wr_go && addr_s == `CBS_ADDR_OUT_CTRL) begin
        out_ctrl_r <= din_s;
      end
    end
  end

  // one shot fires on a rising write of the strobe bit; bit must clear to rearm
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      one_shot_pend_r <= 1'b0;
      one_shot_r      <= 1'b0;
    end else begin
      if (wr_go && addr_s == `CBS_ADDR_SYNC_MODE && din_s[`CBS_SM_ONE_SHOT_BIT] &&
          !sync_mode_r[`CBS_SM_ONE_SHOT_BIT]) begin
        one_shot_pend_r <= 1'b1;
      end else if (tbi.tick) begin
        one_shot_pend_r <= 1'b0;
      end
      if (tbi.tick) begin
        one_shot_r <= one_shot_pend_r;
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic [7:0] rd_mux;
  logic [7:0] status;
  logic       link_mode;
  logic       drive_en;

  assign link_mode = dec_mode_r[`CBS_DM_LINK_BIT];
  assign drive_en  = out_ctrl_r[`CBS_OC_DRIVE_BIT];
  assign status    = {2'h0, ~si_n_s, ack_s, chan_s};

  always_comb begin
    if (addr_s == `CBS_ADDR_SYNC_MODE) begin
      rd_mux = sync_mode_r;
    end else if (addr_s == `CBS_ADDR_DEC_MODE) begin
      rd_mux = dec_mode_r;
    end else if (addr_s == `CBS_ADDR_OUT_CTRL) begin
      rd_mux = out_ctrl_r;
    end else if (addr_s == `CBS_ADDR_STATUS) begin
      rd_mux = status;
    end else begin
      rd_mux = 8'h00;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_data    <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      o_data <= rd_mux;
      // drive only on read cycle; release otherwise
      o_data_oe <= ~cs_n_s & ~rd_n_s & wr_n_s;
    end
  end

  // ****************************************
  // sampling on the timebase edge
  // ****************************************
  logic [2:0] si_pipe_r;
  logic       si_act_r;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_chan_sample <= 4'h0;
    end else if (tbi.tick) begin
      o_chan_sample <= chan_s;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      si_act_r <= 1'b0;
    end else if (tbi.tick) begin
      si_act_r <= ~si_n_s;
    end
  end

  // event marks the tick itself, so it is registered in the same clock that loads si_act_r
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_sync_event <= 1'b0;
    end else begin
      o_sync_event <= tbi.tick & ~si_n_s;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      si_pipe_r <= 3'h0;
    end else if (tbi.tick) begin
      si_pipe_r <= {si_pipe_r[1:0], si_act_r};
    end
  end

  // ****************************************
  // sync output
  // ****************************************
  // input register, pipe taps and the pin flop together make up the delay
  localparam int SO_TAP = `CBS_SO_DELAY_CYC - 2;
  logic so_sel;
  cbs_sync_src_e so_src;

  assign so_src = cbs_sync_src_e'(sync_mode_r[`CBS_SM_OUT_LSB +: 2]);

  always_comb begin
    case (so_src)
      CBS_SYNC_NEVER:  so_sel = 1'b0;
      CBS_SYNC_INPUT:  so_sel = si_pipe_r[SO_TAP];
      CBS_SYNC_COUNT:  so_sel = sync_mode_r[`CBS_SM_USE_OS_BIT] ? one_shot_r :
                                i_counter_terminal_pulse;
      default:         so_sel = 1'b1;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_sync_n <= 1'b1;
    end else if (tbi.tick) begin
      o_sync_n <= ~so_sel;
    end
  end

  // ****************************************
  // ready / acknowledge pin
  // ****************************************
  logic [4:0] rdy_cnt_r;
  logic [4:0] rdy_len;

  assign rdy_len = dec_mode_r[`CBS_DM_RDY_WIDTH_BIT] ? `CBS_RDY_LONG_CYC : `CBS_RDY_SHORT_CYC;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rdy_cnt_r <= 5'h00;
    end else if (i_output_sample_period && !link_mode) begin
      rdy_cnt_r <= rdy_len;
    end else if (rdy_cnt_r != 5'h00 && tbi.phase) begin
      rdy_cnt_r <= rdy_cnt_r - 5'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_ready_ack <= 1'b0;
    end else begin
      o_ready_ack <= (rdy_cnt_r != 5'h00) ^ dec_mode_r[`CBS_DM_READY_POLARITY_BIT_BIT];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_ready_ack_oe <= 1'b0;
    end else begin
      // released until drive bit; input in link mode
      // link set first, else pin drives
      o_ready_ack_oe <= drive_en & ~link_mode;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_link_ack_handshake <= 1'b0;
    end else begin
      o_link_ack_handshake <= link_mode & ack_s;
    end
  end
endmodule // cbs_ctrl_port
`default_nettype wire

/* cbs_ctrl_port_checker.sv */
// Purpose: port assertions for cbs_ctrl_port
// Assumes: host strobes held at least 6 clocks
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module cbs_ctrl_port_checker (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_chip_sel_n,
  input wire logic i_read_n,
  input wire logic i_write_n,
  input wire logic o_data_oe,
  input wire logic i_output_sample_period,
  input wire logic i_sync_n,
  input wire logic o_ready_ack,
  input wire logic o_ready_ack_oe,
  input wire logic o_sync_event,
  input wire logic o_sync_n
);
  // ****************
  // port properties
  // ****************
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  a_read_drive: assert property (
    $rose(o_data_oe) |-> $past(!i_chip_sel_n && !i_read_n, 3))
    else $error("data bus driven without a read");
  a_read_answer: assert property (
    $fell(i_read_n) && !i_chip_sel_n && i_write_n |-> ##[3:6] o_data_oe)
    else $error("read got no data");
  a_bus_release: assert property (
    $rose(i_chip_sel_n) |-> ##[3:6] !o_data_oe)
    else $error("data bus not released");
  a_cs_ignore: assert property (
    i_chip_sel_n [*7] |-> !o_data_oe)
    else $error("bus driven while deselected");
  a_write_quiet: assert property (
    !i_write_n [*7] |-> !o_data_oe)
    else $error("bus driven during write");
  a_ready_start: assert property (
    i_output_sample_period && o_ready_ack_oe |-> ##[1:3] $changed(o_ready_ack))
    else $error("no ready pulse at sample period");
  a_ready_oe: assert property (
    $rose(o_ready_ack_oe) |-> $past(!i_write_n && !i_chip_sel_n, 3))
    else $error("ready pin enabled without a write");
  a_sync_event: assert property (
    $rose(o_sync_event) |-> $past(!i_sync_n, 5))
    else $error("sync event without low sync input");
  a_reset_idle: assert property (disable iff (1'b0)
    i_reset |=> !o_data_oe && !o_ready_ack_oe && o_sync_n)
    else $error("pins not idle in reset");
  c_read: cover property ($rose(o_data_oe));
  c_sync: cover property ($fell(o_sync_n));
  c_ready: cover property ($changed(o_ready_ack) && o_ready_ack_oe);
endmodule // cbs_ctrl_port_checker
`default_nettype wire

/* cbs_host_side.sv */
// Purpose: host side of the data bus and ready/ack wire
// Assumes: one driver at a time
// Notes:   released wires show the inverse of the last level
`timescale 1ns/1ps
`default_nettype none
module cbs_host_side (
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_dev_data,
  input  wire logic       i_dev_oe,
  input  wire logic [7:0] i_host_data,
  input  wire logic       i_host_oe,
  input  wire logic       i_dev_rdy,
  input  wire logic       i_dev_rdy_oe,
  input  wire logic       i_ack,
  input  wire logic       i_ack_oe,
  output logic      [7:0] o_bus,
  output logic            o_rdy_wire
);
  // ****************
  // wire resolution
  // ****************
  logic [7:0] last_r = 8'h00;
  logic       rdy_last_r = 1'b0;
  // no stale value may pass for a driven one
  always_ff @(posedge i_core_clk) begin
    last_r <= o_bus;
    rdy_last_r <= o_rdy_wire;
  end
  assign o_bus = i_dev_oe ? i_dev_data : (i_host_oe ? i_host_data : ~last_r);
  // host acknowledge only while the device releases the wire
  assign o_rdy_wire = i_dev_rdy_oe ? i_dev_rdy : (i_ack_oe ? i_ack : ~rdy_last_r);
endmodule // cbs_host_side
`default_nettype wire

/* testbench.sv */
// Purpose: directed tests of cbs_ctrl_port
// Assumes: timebase of 8 core clocks; one ready case in alternate mode
// Notes:   strobes held 7 clocks, at least 8 clocks apart
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk = 0, rst = 1, cs_n = 1, rd_n = 1, wr_n = 1, hoe = 0, tb = 0;
  logic       output_sample_period = 0, ctp = 0, sync_n = 1, ack = 0, ack_oe = 0, tss = 0, dr = 0;
  logic [4:0] addr = 5'h00;
  logic [7:0] hdata = 8'h00, bus, dq, sm [5];
  logic [3:0] chan = 4'h0, csamp;
  logic       dq_oe, rdy, rdy_oe, link_ack_handshake, so_n, sev, rdy_w;
  int         fail_count = 0, tests_run = 0, cyc = 0, lo_cnt = 0, ev_cnt = 0;
  int         n0, e0, n;
  cbs_ctrl_port i_dut (.i_core_clk(clk), .i_reset(rst), .i_chip_sel_n(cs_n),
    .i_read_n(rd_n), .i_write_n(wr_n), .i_addr(addr), .i_data(bus), .o_data(dq),
    .o_data_oe(dq_oe), .i_sampling_timebase(tb), .i_double_rate_timebase(dr),
    .i_timing_source_select(tss), .i_output_sample_period(output_sample_period),
    .i_counter_terminal_pulse(ctp), .i_chan_data(chan), .i_sync_n(sync_n),
    .i_ready_ack(rdy_w), .o_ready_ack(rdy), .o_ready_ack_oe(rdy_oe),
    .o_link_ack_handshake(link_ack_handshake), .o_sync_n(so_n), .o_sync_event(sev),
    .o_chan_sample(csamp));
  cbs_host_side i_host (.i_core_clk(clk), .i_dev_data(dq), .i_dev_oe(dq_oe),
    .i_host_data(hdata), .i_host_oe(hoe), .i_dev_rdy(rdy), .i_dev_rdy_oe(rdy_oe),
    .i_ack(ack), .i_ack_oe(ack_oe), .o_bus(bus), .o_rdy_wire(rdy_w));
  // ****************
  // clocks and tasks
  // ****************
  initial forever #12.5 clk = ~clk;
  initial forever begin
    repeat (4) @(posedge clk);
    tb <= ~tb;
  end
  // double rate at twice the timebase; held low in normal mode
  initial forever begin
    repeat (2) @(posedge clk);
    dr <= tss ? ~dr : 1'b0;
  end
  always @(posedge clk) begin
    cyc++;
    lo_cnt += (so_n === 1'b0);
    ev_cnt += (sev === 1'b1);
    if (cyc == 6000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic close_out();
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic c = 1'b0);
    @(posedge clk);
    cs_n <= c;
    wr_n <= 1'b0;
    addr <= a;
    hdata <= d;
    hoe <= 1'b1;
    repeat (7) @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    hoe <= 1'b0;
    repeat (7) @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    addr <= a;
    repeat (7) @(posedge clk);
    chk(bus, exp);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (7) @(posedge clk);
    chk(8'(dq_oe), 8'h00);
  endtask
  // one sample period pulse; active length in clocks, 4 clocks per phase step
  task automatic rdy_case(input logic [7:0] mode);
    int w;
    w = mode[3] ? 16 : 4;
    wr(5'h01, mode);
    output_sample_period <= 1'b1;
    @(posedge clk);
    output_sample_period <= 1'b0;
    n = 0;
    repeat (80) @(posedge clk) n += (rdy !== mode[2]);
    chk(8'(n > (w - 1) * 4 && n <= w * 4), 8'h01);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    sm = '{8'h00, 8'he0, 8'h60, 8'h20, 8'h30};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    rd(5'h00, 8'h65);
    rd(5'h01, 8'h00);
    rd(5'h08, 8'h00);
    wr(5'h01, 8'h0b);
    rd(5'h01, 8'h0b);
    wr(5'h01, 8'h55, 1'b1);
    rd(5'h01, 8'h0b);
    wr(5'h1f, 8'hff);
    rd(5'h1f, 8'h00);
    chan <= 4'ha;
    repeat (20) @(posedge clk);
    chk(8'(csamp), 8'h0a);
    chk(8'(rdy_oe), 8'h00);
    wr(5'h08, 8'h01);
    chk(8'(rdy_oe), 8'h01);
    rdy_case(8'h00);
    rdy_case(8'h0c);
    tss <= 1'b1;
    rdy_case(8'h00);
    tss <= 1'b0;
    wr(5'h08, 8'h00);
    // link select goes in before the drive bit
    wr(5'h01, 8'h10);
    wr(5'h08, 8'h01);
    chk(8'(rdy_oe), 8'h00);
    ack_oe <= 1'b1;
    ack <= 1'b1;
    repeat (8) @(posedge clk);
    chk(8'(link_ack_handshake), 8'h01);
    rd(5'h0e, 8'h1a);
    ack <= 1'b0;
    repeat (8) @(posedge clk);
    chk(8'(link_ack_handshake), 8'h00);
    // never, one-shot, one-shot without strobe, terminal pulse, always
    for (int i = 0; i < 5; i++) begin
      ctp <= (i == 2 || i == 3);
      n0 = lo_cnt;
      wr(5'h00, sm[i]);
      repeat (24) @(posedge clk);
      chk(8'(lo_cnt != n0), 8'(i != 0 && i != 2));
    end
    ctp <= 1'b0;
    wr(5'h00, 8'h10);
    repeat (24) @(posedge clk);
    n0 = lo_cnt;
    e0 = ev_cnt;
    repeat (16) @(posedge clk);
    chk(8'(lo_cnt != n0), 8'h00);
    sync_n <= 1'b0;
    repeat (24) @(posedge clk);
    chk(8'(lo_cnt != n0), 8'h00);
    repeat (16) @(posedge clk);
    chk(8'(lo_cnt != n0), 8'h01);
    chk(8'(ev_cnt != e0), 8'h01);
    rd(5'h0e, 8'h2a);
    sync_n <= 1'b1;
    repeat (40) @(posedge clk);
    close_out();
  end
endmodule // testbench
bind cbs_ctrl_port cbs_ctrl_port_checker u_chk (.i_core_clk(i_core_clk),
  .i_reset(i_reset), .i_chip_sel_n(i_chip_sel_n), .i_read_n(i_read_n),
  .i_write_n(i_write_n), .o_data_oe(o_data_oe),
  .i_output_sample_period(i_output_sample_period), .i_sync_n(i_sync_n),
  .o_ready_ack(o_ready_ack), .o_ready_ack_oe(o_ready_ack_oe),
  .o_sync_event(o_sync_event), .o_sync_n(o_sync_n));
`default_nettype wire
